// *** asbb_alu.v ***
// Combinational datapath of the execution slice: result, new flags and
// branch decision for one command.
// Assumes operands and flags are held stable by the caller while it reads.
`default_nettype none
`include "asbb_map.vh"

module asbb_alu #(
  parameter DSP_EN = 1
) (
  input wire [3:0] op_i,
  input wire [4:0] cond_i,
  input wire src_lit_i,
  input wire lit10_i,
  input wire [15:0] opa_i,
  input wire [15:0] opb_i,
  input wire [15:0] lit_i,
  input wire [`ASBB_F_W-1:0] flags_i,
  output reg [15:0] res_o,
  output reg [`ASBB_F_W-1:0] flags_o,
  output reg res_wr_o,
  output reg br_o,
  output reg taken_o,
  output reg [15:0] br_off_o
);

  // ****************************************
  // Branch condition evaluation
  // ****************************************
  // Accumulator tests exist only on the DSP build; elsewhere never taken
  function cond_true;
    input [4:0] cc;
    input [`ASBB_F_W-1:0] f;
    reg c, n, v, z;
    begin
      c = f[`ASBB_F_C];
      n = f[`ASBB_F_N];
      v = f[`ASBB_F_OV];
      z = f[`ASBB_F_Z];
      case (cc)
        `ASBB_CC_C: cond_true = c;
        `ASBB_CC_GE: cond_true = (n == v);
        `ASBB_CC_GT: cond_true = ~z & (n == v);
        `ASBB_CC_LE: cond_true = z | (n != v);
        `ASBB_CC_LT: cond_true = (n != v);
        `ASBB_CC_GEU: cond_true = c;
        `ASBB_CC_GTU: cond_true = c & ~z;
        `ASBB_CC_LEU: cond_true = ~c | z;
        `ASBB_CC_LTU: cond_true = ~c;
        `ASBB_CC_N: cond_true = n;
        `ASBB_CC_NC: cond_true = ~c;
        `ASBB_CC_NN: cond_true = ~n;
        `ASBB_CC_NOV: cond_true = ~v;
        `ASBB_CC_NZ: cond_true = ~z;
        `ASBB_CC_OV: cond_true = v;
        `ASBB_CC_Z: cond_true = z;
        `ASBB_CC_OA: cond_true = (DSP_EN != 0) & f[`ASBB_F_OA];
        `ASBB_CC_OB: cond_true = (DSP_EN != 0) & f[`ASBB_F_OB];
        `ASBB_CC_SA: cond_true = (DSP_EN != 0) & f[`ASBB_F_SA];
        `ASBB_CC_SB: cond_true = (DSP_EN != 0) & f[`ASBB_F_SB];
        default: cond_true = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // Operand selection and adder
  // ****************************************
  wire [15:0] lit_val = lit10_i ? {6'h00, lit_i[9:0]} : {11'h000, lit_i[4:0]};
  wire [15:0] opnd_b = src_lit_i ? lit_val : opb_i; // Literal or register
  wire cin = flags_i[`ASBB_F_C]; // Carry left by the prior command
  wire [16:0] sum = {1'b0, opa_i} + {1'b0, opnd_b} + {16'h0000, cin};
  wire [4:0] nib = {1'b0, opa_i[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
  wire [4:0] amt = src_lit_i ? lit_i[4:0] : {1'b0, opb_i[3:0]};
  wire [15:0] asr_n = $signed(opa_i) >>> amt;
  wire [15:0] one_hot_bit = 16'h0001 << lit_i[3:0];
  wire [15:0] bsw_bit = 16'h0001 << opb_i[3:0];

  // ****************************************
  // Result and flag generation
  // ****************************************
  always @* begin
    res_o = opa_i;
    flags_o = flags_i;
    res_wr_o = 1'b0;
    br_o = 1'b0;
    taken_o = 1'b0;
    br_off_o = lit_i;
    case (op_i)
      `ASBB_OP_ADD_WITH_CARRY_OP: begin
        res_o = sum[15:0];
        res_wr_o = 1'b1;
        flags_o[`ASBB_F_C] = sum[16];
        flags_o[`ASBB_F_DC] = nib[4];
        flags_o[`ASBB_F_N] = sum[15];
        flags_o[`ASBB_F_OV] = (opa_i[15] == opnd_b[15]) & (sum[15] != opa_i[15]);
        flags_o[`ASBB_F_Z] = (sum[15:0] == 16'h0000);
      end
      `ASBB_OP_AND: begin
        res_o = opa_i & opnd_b;
        res_wr_o = 1'b1;
        flags_o[`ASBB_F_N] = res_o[15];
        flags_o[`ASBB_F_Z] = (res_o == 16'h0000);
      end
      `ASBB_OP_ASR1: begin
        res_o = {opa_i[15], opa_i[15:1]};
        res_wr_o = 1'b1;
        flags_o[`ASBB_F_C] = opa_i[0];
        flags_o[`ASBB_F_N] = opa_i[15];
        flags_o[`ASBB_F_OV] = 1'b0;
        flags_o[`ASBB_F_Z] = (res_o == 16'h0000);
      end
      `ASBB_OP_ASRN: begin
        res_o = asr_n;
        res_wr_o = 1'b1;
        flags_o[`ASBB_F_N] = asr_n[15];
        flags_o[`ASBB_F_Z] = (asr_n == 16'h0000);
      end
      `ASBB_OP_BIT_SET_OP: begin
        res_o = opa_i | one_hot_bit;
        res_wr_o = 1'b1;
      end
      `ASBB_OP_BIT_CLEAR_OP: begin
        res_o = opa_i & ~one_hot_bit;
        res_wr_o = 1'b1;
      end
      `ASBB_OP_BSW: begin
        // Condition field bit 0 picks zero (1) or carry (0)
        if (cond_i[0] ? flags_i[`ASBB_F_Z] : flags_i[`ASBB_F_C]) begin
          res_o = opa_i | bsw_bit;
        end else begin
          res_o = opa_i & ~bsw_bit;
        end
        res_wr_o = 1'b1;
      end
      `ASBB_OP_BRC: begin
        br_o = 1'b1;
        taken_o = cond_true(cond_i, flags_i);
      end
      `ASBB_OP_BRA: begin
        br_o = 1'b1;
        taken_o = 1'b1;
      end
      `ASBB_OP_BRW: begin
        br_o = 1'b1;
        taken_o = 1'b1;
        br_off_o = opb_i;
      end
      default: begin
        res_wr_o = 1'b0; // Undefined code acts as a no-op
      end
    endcase
  end

endmodule
`default_nettype wire

// *** asbb_checker.sv ***
// Port-level checks of the execution slice: instruction timing seen on
// busy, and the Avalon-MM handshake.
// Assumes one clock, synchronous active-high reset, byte addresses.
`default_nettype none
`include "asbb_map.vh"

module asbb_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Command decode at the accepting edge
  // ****************************************
  wire logic launch; // Command write taken this cycle
  wire logic [3:0] wop; // Opcode being launched
  wire logic wsfr; // Non-core register target
  wire logic core_op; // Datapath op, not a branch
  assign launch = avs_write_i & ~avs_read_i & ~avs_waitrequest_o
    & (avs_address_i == `ASBB_OFF_CMD) & avs_byteenable_i[0];
  assign wop = avs_writedata_i[`ASBB_CMD_OP];
  assign wsfr = avs_writedata_i[`ASBB_CMD_SFR];
  assign core_op = (wop <= `ASBB_OP_BSW);

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ****************************************
  // Busy shapes, one per cycle count
  // ****************************************
  sequence s_busy1;
    busy_o ##1 !busy_o;
  endsequence
  sequence s_busy2;
    busy_o [*2] ##1 !busy_o;
  endsequence
  sequence s_busy4;
    busy_o [*4] ##1 !busy_o;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  a_alu_one_cycle: assert property (
    launch && core_op && !wsfr |=> s_busy1) else $error("datapath op not one cycle");
  a_sfr_extra_cycle: assert property (
    launch && core_op && wsfr |=> s_busy2) else $error("non-core target not two cycles");
  a_cond_branch_time: assert property (
    launch && wop == `ASBB_OP_BRC |=> s_busy1 or s_busy4) else $error("cond branch timing");
  a_uncond_four: assert property (
    launch && (wop == `ASBB_OP_BRA || wop == `ASBB_OP_BRW) |=> s_busy4)
    else $error("uncond branch not four cycles");
  a_busy_needs_launch: assert property (
    !busy_o && !launch |=> !busy_o) else $error("busy without a command");
  a_write_stalled: assert property (
    busy_o && avs_write_i |-> avs_waitrequest_o) else $error("write accepted while busy");
  a_idle_write_fast: assert property (
    avs_write_i && !avs_read_i && !busy_o |-> !avs_waitrequest_o)
    else $error("idle write stalled");
  a_read_latency: assert property (
    avs_read_i && !$past(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read answer not in second cycle");
  a_unmapped_zero: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h1c |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind asbb_top asbb_checker u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .busy_o(busy_o));
`default_nettype wire

// *** asbb_map.vh ***
// Register map, command fields, flag positions and cycle counts of the
// add/shift/bit/branch execution slice.
// Assumes byte addresses on a 32-bit Avalon-MM slave, one word per register.
`ifndef ASBB_MAP_VH
`define ASBB_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define ASBB_OFF_CMD 8'h00
`define ASBB_OFF_OPA 8'h04
`define ASBB_OFF_OPB 8'h08
`define ASBB_OFF_LIT 8'h0c
`define ASBB_OFF_STATUS 8'h10
`define ASBB_OFF_RESULT 8'h14
`define ASBB_OFF_PC 8'h18
`define ASBB_OFF_CYCLES 8'h1c

// ****************************************
// Command register fields
// ****************************************
`define ASBB_CMD_OP 3:0
`define ASBB_CMD_COND 8:4
`define ASBB_CMD_SRC_LIT 9
`define ASBB_CMD_LIT10 10
`define ASBB_CMD_DST 12:11
`define ASBB_CMD_SFR 13
`define ASBB_CMD_W 14

// ****************************************
// Operation codes
// ****************************************
`define ASBB_OP_ADD_WITH_CARRY_OP 4'h0
`define ASBB_OP_AND 4'h1
`define ASBB_OP_ASR1 4'h2
`define ASBB_OP_ASRN 4'h3
`define ASBB_OP_BIT_SET_OP 4'h4
`define ASBB_OP_BIT_CLEAR_OP 4'h5
`define ASBB_OP_BSW 4'h6
`define ASBB_OP_BRC 4'h7
`define ASBB_OP_BRA 4'h8
`define ASBB_OP_BRW 4'h9

// ****************************************
// Status flag positions and reset value
// ****************************************
`define ASBB_F_C 0
`define ASBB_F_DC 1
`define ASBB_F_N 2
`define ASBB_F_OV 3
`define ASBB_F_Z 4
`define ASBB_F_OA 5
`define ASBB_F_OB 6
`define ASBB_F_SA 7
`define ASBB_F_SB 8
`define ASBB_F_W 9
`define ASBB_ST_BUSY 15
`define ASBB_ST_RST 9'h000

// ****************************************
// Branch condition codes
// ****************************************
`define ASBB_CC_C 5'h00
`define ASBB_CC_GE 5'h01
`define ASBB_CC_GEU 5'h02
`define ASBB_CC_GT 5'h03
`define ASBB_CC_GTU 5'h04
`define ASBB_CC_LE 5'h05
`define ASBB_CC_LEU 5'h06
`define ASBB_CC_LT 5'h07
`define ASBB_CC_LTU 5'h08
`define ASBB_CC_N 5'h09
`define ASBB_CC_NC 5'h0a
`define ASBB_CC_NN 5'h0b
`define ASBB_CC_NOV 5'h0c
`define ASBB_CC_NZ 5'h0d
`define ASBB_CC_OA 5'h0e
`define ASBB_CC_OB 5'h0f
`define ASBB_CC_OV 5'h10
`define ASBB_CC_SA 5'h11
`define ASBB_CC_SB 5'h12
`define ASBB_CC_Z 5'h13

// ****************************************
// Instruction cycle counts
// ****************************************
`define ASBB_CYC_BASE 3'h1
`define ASBB_CYC_TAKEN 3'h4
`define ASBB_CYC_SFR 3'h1

`endif

// *** asbb_top.v ***
// Top of the add/shift/bit/branch execution slice: Avalon-MM register
// file, command sequencer with instruction cycle timing, program counter.
// Assumes one clock; the clock edge stands for one instruction cycle.
//
// Functional notes
// - add-with-carry sums operands plus carry flag
// - AND updates only negative and zero flags
// - single arithmetic shift keeps sign, sets C,N,OV,Z
// - multi shift by register updates N,Z only
// - multi shift by 5-bit literal updates N,Z
// - bit set/clear, 4-bit position, one cycle, no flags
// - copy carry or zero into indexed bit
// - conditional branch: one cycle, four if taken
// - signed compare branches use N, OV, Z
// - unsigned compare branches use C and Z
// - accumulator branches only on DSP build
// - unconditional and computed branches take four cycles
// - non-core special register access adds one cycle
`default_nettype none
`include "asbb_map.vh"

module asbb_top #(
  parameter DSP_EN = 1
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  output wire busy_o
);

  // ****************************************
  // State encoding
  // ****************************************
  localparam [1:0] ST_IDLE = 2'b01; // Waiting for a command
  localparam [1:0] ST_EXEC = 2'b10; // Counting instruction cycles

  // ****************************************
  // Storage
  // ****************************************
  reg [1:0] state; // One-hot sequencer state
  reg [`ASBB_CMD_W-1:0] cmd; // Latched command word
  reg [15:0] opa; // File register or base/source operand
  reg [15:0] opb; // Default or second working register
  reg [15:0] lit; // Literal, bit position or shift amount
  reg [`ASBB_F_W-1:0] status; // Status flags
  reg [15:0] result; // Last written result
  reg [1:0] result_dst; // Destination tag of the last result
  reg [15:0] pc; // Program counter, in instruction words
  reg [2:0] cyc_cnt; // Cycles spent so far in this command
  reg [2:0] last_cyc; // Cycle count of the last command
  reg rd_valid; // Read data staged for the master

  // ****************************************
  // Datapath outputs
  // ****************************************
  wire [15:0] alu_res;
  wire [`ASBB_F_W-1:0] alu_flags;
  wire alu_res_wr;
  wire alu_br;
  wire alu_taken;
  wire [15:0] alu_off;
  wire [2:0] need_cyc;
  wire [15:0] st_merged; // Status word after a byte-lane write

  // ****************************************
  // Helper functions
  // ****************************************
  // Byte-lane merge for the 16-bit registers
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // Cycle budget of one command from its branch outcome and target
  function [2:0] cycles_for;
    input br;
    input taken;
    input sfr;
    reg [2:0] base;
    begin
      base = taken ? `ASBB_CYC_TAKEN : `ASBB_CYC_BASE;
      // Branches never touch a special register, so no penalty there
      cycles_for = (sfr & ~br) ? base + `ASBB_CYC_SFR : base;
    end
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  wire is_idle = state[0];
  wire is_exec = state[1];
  wire wr_hit = avs_write_i & ~avs_read_i;
  // Writes stall while a command runs so operands cannot shift under it
  wire wr_stall = wr_hit & is_exec;
  wire wr_take = wr_hit & ~is_exec;
  wire rd_take = avs_read_i & rd_valid;
  wire cmd_go = wr_take & (avs_address_i == `ASBB_OFF_CMD) & avs_byteenable_i[0];
  wire last_cycle = is_exec & (cyc_cnt == need_cyc);

  // Reads take one wait cycle so read data leave a flip-flop
  assign avs_waitrequest_o = wr_stall | (avs_read_i & ~rd_valid);
  assign busy_o = is_exec;

  // ****************************************
  // Datapath instance
  // ****************************************
  asbb_alu #(
    .DSP_EN(DSP_EN)
  ) u_alu (
    .op_i(cmd[`ASBB_CMD_OP]),
    .cond_i(cmd[`ASBB_CMD_COND]),
    .src_lit_i(cmd[`ASBB_CMD_SRC_LIT]),
    .lit10_i(cmd[`ASBB_CMD_LIT10]),
    .opa_i(opa),
    .opb_i(opb),
    .lit_i(lit),
    .flags_i(status),
    .res_o(alu_res),
    .flags_o(alu_flags),
    .res_wr_o(alu_res_wr),
    .br_o(alu_br),
    .taken_o(alu_taken),
    .br_off_o(alu_off)
  );

  assign need_cyc = cycles_for(alu_br, alu_taken, cmd[`ASBB_CMD_SFR]);
  // Upper bits of the merged word are the read-only busy area, dropped here
  assign st_merged = merge16({7'h00, status}, avs_writedata_i, avs_byteenable_i);

  // ****************************************
  // Sequencer
  // ****************************************
  // Command accepted from idle, then held until its cycle budget is spent
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      cmd <= {`ASBB_CMD_W{1'b0}};
      cyc_cnt <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_go) begin
            cmd <= avs_writedata_i[`ASBB_CMD_W-1:0];
            cyc_cnt <= 3'h1;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (last_cycle) begin
            state <= ST_IDLE;
          end else begin
            cyc_cnt <= cyc_cnt + 3'h1;
          end
        end
        default: begin
          state <= ST_IDLE; // Recover from an illegal code
        end
      endcase
    end
  end

  // ****************************************
  // Operand registers
  // ****************************************
  // Software loads operands only while idle
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      opa <= 16'h0000;
      opb <= 16'h0000;
      lit <= 16'h0000;
    end else if (wr_take) begin
      if (avs_address_i == `ASBB_OFF_OPA) begin
        opa <= merge16(opa, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `ASBB_OFF_OPB) begin
        opb <= merge16(opb, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `ASBB_OFF_LIT) begin
        lit <= merge16(lit, avs_writedata_i, avs_byteenable_i);
      end
    end
  end

  // ****************************************
  // Status, result and program counter
  // ****************************************
  // Commit lands on the last cycle; the next command cannot be accepted
  // before that edge, so it always sees the fresh flags
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      status <= `ASBB_ST_RST;
      result <= 16'h0000;
      result_dst <= 2'h0;
      pc <= 16'h0000;
      last_cyc <= 3'h0;
    end else if (last_cycle) begin
      status <= alu_flags;
      last_cyc <= need_cyc;
      if (alu_res_wr) begin
        result <= alu_res;
        result_dst <= cmd[`ASBB_CMD_DST];
      end
      // Taken branches skip ahead by a signed word offset
      if (alu_taken) begin
        pc <= pc + 16'h0001 + alu_off;
      end else begin
        pc <= pc + 16'h0001;
      end
    end else if (wr_take) begin
      if (avs_address_i == `ASBB_OFF_STATUS) begin
        status <= st_merged[`ASBB_F_W-1:0];
      end else if (avs_address_i == `ASBB_OFF_PC) begin
        pc <= merge16(pc, avs_writedata_i, avs_byteenable_i);
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // First read cycle stages data, second hands it over
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_valid <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_take) begin
      rd_valid <= 1'b0;
    end else if (avs_read_i) begin
      rd_valid <= 1'b1;
      if (avs_address_i == `ASBB_OFF_CMD) begin
        avs_readdata_o <= {18'h00000, cmd};
      end else if (avs_address_i == `ASBB_OFF_OPA) begin
        avs_readdata_o <= {16'h0000, opa};
      end else if (avs_address_i == `ASBB_OFF_OPB) begin
        avs_readdata_o <= {16'h0000, opb};
      end else if (avs_address_i == `ASBB_OFF_LIT) begin
        avs_readdata_o <= {16'h0000, lit};
      end else if (avs_address_i == `ASBB_OFF_STATUS) begin
        avs_readdata_o <= {16'h0000, is_exec, 6'h00, status};
      end else if (avs_address_i == `ASBB_OFF_RESULT) begin
        avs_readdata_o <= {14'h0000, result_dst, result};
      end else if (avs_address_i == `ASBB_OFF_PC) begin
        avs_readdata_o <= {16'h0000, pc};
      end else if (avs_address_i == `ASBB_OFF_CYCLES) begin
        avs_readdata_o <= {29'h00000000, last_cyc};
      end else begin
        avs_readdata_o <= 32'h0000_0000; // Unmapped reads as zero
      end
    end
  end

endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the execution slice: random commands through the
// register bus, compared with a bench model of results, flags, PC, cycles.
// Assumes the checker is bound to the top from its own file.
`default_nettype none
`include "asbb_map.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Stimulus, model state, counters
  // ****************************************
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h3;
  wire logic [31:0] avs_readdata_o;
  wire logic avs_waitrequest_o;
  wire logic busy_o;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0; // Cycles since start, for the hang limit
  logic [8:0] m_fl = 9'h0; // Expected flags
  logic [15:0] m_pc = 16'h0; // Expected program counter
  logic [17:0] m_res = 18'h0; // Expected tag and result
  logic [2:0] m_cyc = 3'h0; // Expected cycle count
  logic [31:0] rd; // Last read data

  always #4 clk_i = ~clk_i;

  asbb_top #(.DSP_EN(1)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .busy_o(busy_o));

  // ****************************************
  // Verdict, compare, bus access
  // ****************************************
  task automatic complete_run();
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One transfer; waitrequest is looked at mid-cycle, where it is settled
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= {2'($urandom), 2'b11}; // Upper lanes are ignored
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(negedge clk_i);
      w = avs_waitrequest_o;
      rd = avs_readdata_o;
      @(posedge clk_i);
    end while (w !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i); // Idle cycle so no signal is driven twice in one step
  endtask

  // ****************************************
  // Expectation functions
  // ****************************************
  function automatic logic fcond(input logic [4:0] cc, input logic [8:0] f);
    logic c, n, v, z;
    {z, v, n, c} = {f[4], f[3], f[2], f[0]};
    case (cc)
      5'h00, 5'h02: return c;
      5'h01: return n == v;
      5'h03: return !z && n == v;
      5'h04: return c && !z;
      5'h05: return z || n != v;
      5'h06: return !c || z;
      5'h07: return n != v;
      5'h08, 5'h0a: return !c;
      5'h09: return n;
      5'h0b: return !n;
      5'h0c: return !v;
      5'h0d: return !z;
      5'h0e: return f[5];
      5'h0f: return f[6];
      5'h10: return v;
      5'h11: return f[7];
      5'h12: return f[8];
      5'h13: return z;
      default: return 1'b0; // Unused codes never branch
    endcase
  endfunction

  // Returns {dest tag, result, flags} of a datapath op
  function automatic logic [26:0] alu(input logic [13:0] c, input logic [15:0] a, b, l,
                                      input logic [8:0] f);
    logic [16:0] s;
    logic [4:0] h;
    logic [15:0] y, r;
    y = c[9] ? (c[10] ? {6'h0, l[9:0]} : {11'h0, l[4:0]}) : b;
    r = a;
    case (c[3:0])
      4'h0: begin // Carry in is the flag left by the previous command
        s = a + y + f[0];
        h = a[3:0] + y[3:0] + f[0];
        r = s[15:0];
        f[0] = s[16];
        f[1] = h[4];
        f[3] = (a[15] == y[15]) && (r[15] != a[15]);
      end
      4'h1: r = a & y;
      4'h2: begin // Sign kept, shifted-out bit to carry
        r = {a[15], a[15:1]};
        f[0] = a[0];
        f[3] = 1'b0;
      end
      4'h3: r = $signed(a) >>> (c[9] ? l[4:0] : {1'b0, b[3:0]});
      4'h4: r = a | (16'h1 << l[3:0]);
      4'h5: r = a & ~(16'h1 << l[3:0]);
      default: r[b[3:0]] = c[4] ? f[4] : f[0];
    endcase
    if (c[3:0] <= 4'h3) begin
      f[2] = r[15];
      f[4] = (r == 16'h0);
    end
    return {c[12:11], r, f};
  endfunction

  // One command with operands, optional status preset, and full readback
  task automatic run(input logic [13:0] c, input logic [15:0] a, b, l,
                     input logic wst, input logic [8:0] fs);
    logic t;
    bus(1'b1, `ASBB_OFF_OPA, {16'h0, a});
    bus(1'b1, `ASBB_OFF_OPB, {16'h0, b});
    bus(1'b1, `ASBB_OFF_LIT, {16'h0, l});
    if (wst) begin
      bus(1'b1, `ASBB_OFF_STATUS, {23'h0, fs});
      m_fl = fs;
    end
    t = c[3:0] == 4'h8 || c[3:0] == 4'h9 || (c[3:0] == 4'h7 && fcond(c[8:4], m_fl));
    m_cyc = t ? 3'h4 : 3'h1 + 3'(c[13] && c[3:0] <= 4'h6);
    m_pc = m_pc + 16'h1 + (t ? (c[3:0] == 4'h9 ? b : l) : 16'h0);
    if (c[3:0] <= 4'h6) {m_res, m_fl} = alu(c, a, b, l, m_fl);
    bus(1'b1, `ASBB_OFF_CMD, {18'h0, c});
    do @(negedge clk_i); while (busy_o !== 1'b0);
    @(posedge clk_i);
    bus(1'b0, `ASBB_OFF_RESULT, 32'h0);
    check("result", rd, {14'h0, m_res});
    bus(1'b0, `ASBB_OFF_STATUS, 32'h0);
    check("status", rd, {23'h0, m_fl});
    bus(1'b0, `ASBB_OFF_PC, 32'h0);
    check("pc", {16'h0, rd[15:0]}, {16'h0, m_pc});
    bus(1'b0, `ASBB_OFF_CYCLES, 32'h0);
    check("cycles", rd, {29'h0, m_cyc});
  endtask

  // ****************************************
  // Hang limit and main sequence
  // ****************************************
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    logic [13:0] c;
    void'($urandom(32'h7e945915));
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    // All registers clear after reset, unmapped place reads zero
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      check("reset value", rd, 32'h0);
    end
    // Carry in wraps to zero, then signed overflow
    run(14'h0000, 16'hffff, 16'h0000, 16'h0000, 1'b1, 9'h001);
    run(14'h0000, 16'h7fff, 16'h0000, 16'h0000, 1'b1, 9'h001);
    // Every condition code, twice with random flags
    for (int cc = 0; cc < 42; cc++)
      run({5'h0, 5'(cc % 21), 4'h7}, 16'($urandom), 16'($urandom), 16'($urandom),
          1'b1, 9'($urandom));
    // Register write held off by a running branch
    bus(1'b1, `ASBB_OFF_CMD, 32'h8);
    bus(1'b1, `ASBB_OFF_PC, 32'h1234);
    m_pc = 16'h1234;
    bus(1'b0, `ASBB_OFF_PC, 32'h0);
    check("pc after stall", {16'h0, rd[15:0]}, 32'h1234);
    bus(1'b1, 8'h24, 32'hffff); // Unmapped write must change nothing
    // Random commands, flags often left over from the previous one
    repeat (300) begin
      c = 14'($urandom);
      c[3:0] = 4'($urandom % 10);
      run(c, 16'($urandom), 16'($urandom), 16'($urandom), 1'($urandom), 9'($urandom));
    end
    complete_run();
  end
endmodule
`default_nettype wire
